// [common/gpl_pkg.sv]
package gpl_pkg;
  localparam int unsigned GPL_DATA_W = 32;
  localparam int unsigned GPL_ADDR_W = 8;
  localparam int unsigned GPL_A_PINS = 8;
  localparam int unsigned GPL_B_PINS = 4;
  localparam int unsigned GPL_REG_W = 8;
  // byte addresses of the register words
  localparam logic [7:0] GPL_OFS_A_DATA = 8'h00;
  localparam logic [7:0] GPL_OFS_A_DIR = 8'h04;
  localparam logic [7:0] GPL_OFS_B_DATA = 8'h08;
  localparam logic [7:0] GPL_OFS_B_DIR = 8'h0C;
  localparam logic [7:0] GPL_OFS_CTRL = 8'h10;
  localparam logic [7:0] GPL_OFS_STAT = 8'h14;
  // control register fields
  localparam int unsigned GPL_CTRL_FLOAT_BIT = 0;
  localparam int unsigned GPL_CTRL_RMW_BIT = 1;
  // status register fields
  localparam int unsigned GPL_STAT_STBY_BIT = 0;
  localparam int unsigned GPL_STAT_ISO_BIT = 1;
  localparam logic [7:0] GPL_DIR_RESET = 8'h00;
  localparam logic [7:0] GPL_DATA_RESET = 8'h00;
  localparam logic [1:0] GPL_CTRL_RESET = 2'h0;

  typedef enum logic [2:0] {
    GPL_RUN = 3'b001,
    GPL_STBY_HOLD = 3'b010,
    GPL_STBY_FLOAT = 3'b100
  } gpl_mode_e;
endpackage

// [rtl/gpl_pin_bank.sv]
`timescale 1ns/100ps
// one port's pins: output drive, pin sampling and standby isolation
module gpl_pin_bank #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  input wire logic isolate,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_level
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_oe[g] <= 1'b0;
          pin_out[g] <= 1'b0;
          pin_level[g] <= 1'b0;
        end else begin
          pin_oe[g] <= dir[g] & ~isolate;
          pin_out[g] <= latch[g];
          // input held low while isolated so a floating pin draws no leakage
          pin_level[g] <= pin_in[g] & ~isolate;
        end
      end
    end
  endgenerate

  chk_iso_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
    isolate |=> (pin_oe == '0) && (pin_level == '0))
    else $error("pins not floated in isolation");
endmodule

// [rtl/gpl_apb_slave.sv]
`timescale 1ns/100ps
// apb slave framing: zero wait states, error on unmapped word
module gpl_apb_slave (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic hit,
  output logic pready,
  output logic pslverr,
  output logic wr_en,
  output logic rd_en
);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_en = psel & ~penable & ~pwrite;

  chk_apb_ready: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (psel && !penable) |=> (!penable || pready))
    else $error("access phase without ready");
endmodule

// [rtl/gpl_ports.sv]
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
// Operation
// - direction bit one makes the pin an output driven from its latch bit
// - an output pin shows the stored data bit
// - data writes update the latch and show at once on output pins; the code shows them one clock after the latch, through the pin bank register
// - reading an output pin's data bit returns the latch
// - direction zero is input; data writes still update the unseen latch
// - input pins read the pin level; read-modify-write reads return the latch
// - eight-pin port bits seven to zero map to pins seven to zero
// - four-pin port has only bits three to zero
// - reset clears every direction bit so all pins are inputs
// - stop or watch with float bit set floats pins and blocks inputs low
// - stop or watch with float bit clear keeps pin states and outputs
// - during reset pins float with input path enabled; the code holds the sampled pin level at zero until reset ends
module gpl_ports
  import gpl_pkg::*;
#(
  parameter int unsigned A_PINS = GPL_A_PINS,
  parameter int unsigned B_PINS = GPL_B_PINS
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [gpl_pkg::GPL_ADDR_W-1:0] PADDR,
  input wire logic [gpl_pkg::GPL_DATA_W-1:0] PWDATA,
  output logic [gpl_pkg::GPL_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STANDBY_REQ,
  input wire logic [A_PINS-1:0] PORT_A_IN,
  output logic [A_PINS-1:0] PORT_A_OUT,
  output logic [A_PINS-1:0] PORT_A_OE,
  input wire logic [B_PINS-1:0] PORT_B_IN,
  output logic [B_PINS-1:0] PORT_B_OUT,
  output logic [B_PINS-1:0] PORT_B_OE
);
  import gpl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [A_PINS-1:0] port_a_data_latch;
  logic [A_PINS-1:0] port_a_direction;
  logic [B_PINS-1:0] port_b_data_latch;
  logic [B_PINS-1:0] port_b_direction;
  logic standby_pin_float;
  logic rmw_read;
  logic [A_PINS-1:0] a_level;
  logic [B_PINS-1:0] b_level;
  logic hit;
  logic wr_en;
  logic rd_en;
  logic isolate;
  gpl_mode_e mode;
  gpl_mode_e next_mode;
  logic [GPL_DATA_W-1:0] next_rdata;

  function automatic logic is_ofs(input logic [GPL_ADDR_W-1:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  always_comb begin
    hit = 1'b0;
    if (is_ofs(PADDR, GPL_OFS_A_DATA)) begin
      hit = 1'b1;
    end else if (is_ofs(PADDR, GPL_OFS_A_DIR)) begin
      hit = 1'b1;
    end else if (is_ofs(PADDR, GPL_OFS_B_DATA)) begin
      hit = 1'b1;
    end else if (is_ofs(PADDR, GPL_OFS_B_DIR)) begin
      hit = 1'b1;
    end else if (is_ofs(PADDR, GPL_OFS_CTRL)) begin
      hit = 1'b1;
    end else if (is_ofs(PADDR, GPL_OFS_STAT)) begin
      hit = 1'b1;
    end
  end

  gpl_apb_slave u_apb (
    .sys_clk(SYS_CLK),
    .rst_b(RST_B),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .hit(hit),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .wr_en(wr_en),
    .rd_en(rd_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      port_a_data_latch <= GPL_DATA_RESET[A_PINS-1:0];
      port_a_direction <= GPL_DIR_RESET[A_PINS-1:0];
    end else if (wr_en && is_ofs(PADDR, GPL_OFS_A_DATA)) begin
      port_a_data_latch <= PWDATA[A_PINS-1:0];
    end else if (wr_en && is_ofs(PADDR, GPL_OFS_A_DIR)) begin
      port_a_direction <= PWDATA[A_PINS-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      port_b_data_latch <= GPL_DATA_RESET[B_PINS-1:0];
      port_b_direction <= GPL_DIR_RESET[B_PINS-1:0];
    end else if (wr_en && is_ofs(PADDR, GPL_OFS_B_DATA)) begin
      // upper write bits have no storage behind them
      port_b_data_latch <= PWDATA[B_PINS-1:0];
    end else if (wr_en && is_ofs(PADDR, GPL_OFS_B_DIR)) begin
      port_b_direction <= PWDATA[B_PINS-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      standby_pin_float <= GPL_CTRL_RESET[GPL_CTRL_FLOAT_BIT];
      rmw_read <= GPL_CTRL_RESET[GPL_CTRL_RMW_BIT];
    end else if (wr_en && is_ofs(PADDR, GPL_OFS_CTRL)) begin
      standby_pin_float <= PWDATA[GPL_CTRL_FLOAT_BIT];
      rmw_read <= PWDATA[GPL_CTRL_RMW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby mode: float bit is sampled on entry and held for the stay
  always_comb begin
    next_mode = mode;
    case (mode)
      GPL_RUN: begin
        if (STANDBY_REQ) begin
          next_mode = standby_pin_float ? GPL_STBY_FLOAT : GPL_STBY_HOLD;
        end
      end
      GPL_STBY_HOLD, GPL_STBY_FLOAT: begin
        if (!STANDBY_REQ) begin
          next_mode = GPL_RUN;
        end
      end
      default: next_mode = GPL_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode <= GPL_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign isolate = (mode == GPL_STBY_FLOAT);

  ////////////////////////////////////////////////////////////////////////////
  // pins; output enables are zero in reset so every pin floats
  gpl_pin_bank #(.WIDTH(A_PINS)) u_bank_a (
    .sys_clk(SYS_CLK),
    .rst_b(RST_B),
    .latch(port_a_data_latch),
    .dir(port_a_direction),
    .isolate(isolate),
    .pin_in(PORT_A_IN),
    .pin_out(PORT_A_OUT),
    .pin_oe(PORT_A_OE),
    .pin_level(a_level)
  );

  gpl_pin_bank #(.WIDTH(B_PINS)) u_bank_b (
    .sys_clk(SYS_CLK),
    .rst_b(RST_B),
    .latch(port_b_data_latch),
    .dir(port_b_direction),
    .isolate(isolate),
    .pin_in(PORT_B_IN),
    .pin_out(PORT_B_OUT),
    .pin_oe(PORT_B_OE),
    .pin_level(b_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data: captured at setup so it is stable through the access phase
  always_comb begin
    next_rdata = '0;
    if (is_ofs(PADDR, GPL_OFS_A_DATA)) begin
      // output pins return the latch; inputs the pin unless rmw read
      next_rdata[A_PINS-1:0] = rmw_read ? port_a_data_latch :
        ((port_a_direction & port_a_data_latch) | (~port_a_direction & a_level));
    end else if (is_ofs(PADDR, GPL_OFS_A_DIR)) begin
      next_rdata[A_PINS-1:0] = port_a_direction;
    end else if (is_ofs(PADDR, GPL_OFS_B_DATA)) begin
      next_rdata[B_PINS-1:0] = rmw_read ? port_b_data_latch :
        ((port_b_direction & port_b_data_latch) | (~port_b_direction & b_level));
    end else if (is_ofs(PADDR, GPL_OFS_B_DIR)) begin
      next_rdata[B_PINS-1:0] = port_b_direction;
    end else if (is_ofs(PADDR, GPL_OFS_CTRL)) begin
      next_rdata[GPL_CTRL_FLOAT_BIT] = standby_pin_float;
      next_rdata[GPL_CTRL_RMW_BIT] = rmw_read;
    end else if (is_ofs(PADDR, GPL_OFS_STAT)) begin
      next_rdata[GPL_STAT_STBY_BIT] = (mode != GPL_RUN);
      next_rdata[GPL_STAT_ISO_BIT] = isolate;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= '0;
    end else if (rd_en) begin
      PRDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_dir_reset: assert property (@(posedge SYS_CLK)
    $rose(RST_B) |-> (port_a_direction == '0) && (port_b_direction == '0))
    else $error("direction not cleared by reset");
  chk_out_drive: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (mode == GPL_RUN) ##1 (mode == GPL_RUN) |-> PORT_A_OE == $past(port_a_direction))
    else $error("output enable does not follow direction");
  chk_out_level: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ##1 PORT_A_OUT == $past(port_a_data_latch))
    else $error("pin level differs from latch");
  chk_write_show: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (wr_en && is_ofs(PADDR, GPL_OFS_A_DATA)) |=> ##1 PORT_A_OUT == $past(PWDATA[A_PINS-1:0], 2))
    else $error("written data not on pins");
  chk_read_out: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (rd_en && is_ofs(PADDR, GPL_OFS_A_DATA) && port_a_direction == '1)
    |=> PRDATA[A_PINS-1:0] == $past(port_a_data_latch))
    else $error("output read not latch");
  chk_input_hiz: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (port_b_direction == '0) |=> PORT_B_OE == '0)
    else $error("input pin driven");
  chk_rmw_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (rd_en && rmw_read && is_ofs(PADDR, GPL_OFS_B_DATA))
    |=> PRDATA[B_PINS-1:0] == $past(port_b_data_latch))
    else $error("rmw read not latch");
  chk_upper_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (rd_en && is_ofs(PADDR, GPL_OFS_B_DIR)) |=> PRDATA[GPL_REG_W-1:B_PINS] == '0)
    else $error("upper bits not zero");
  chk_hold_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (mode == GPL_STBY_HOLD && $stable(port_a_direction)) |=> PORT_A_OE == $past(PORT_A_OE))
    else $error("hold standby changed pins");

  cov_float: cover property (@(posedge SYS_CLK) mode == GPL_STBY_FLOAT);
  cov_hold: cover property (@(posedge SYS_CLK) mode == GPL_STBY_HOLD);
  cov_rmw: cover property (@(posedge SYS_CLK) rd_en && rmw_read);
endmodule

// [tb/gpl_pin_model.sv]
`timescale 1ns/100ps
// far side of one port: a driven pin shows the port, an undriven one the outside source
module gpl_pin_model #(
  parameter int unsigned W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_level
);
  // the source backs off wherever the port drives, so no contention is modelled
  // pins are assumed handed to the port: segment and bias selects cleared,
  // input control set, so the lcd controller never drives here
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import gpl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stby = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] a_in, a_out, a_oe;
  logic [7:0] a_ext = 8'h3c;
  logic [3:0] b_in, b_out, b_oe;
  logic [3:0] b_ext = 4'h9;
  int num_errors = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;

  gpl_ports u_gpl_ports (.SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .STANDBY_REQ(stby), .PORT_A_IN(a_in), .PORT_A_OUT(a_out),
    .PORT_A_OE(a_oe), .PORT_B_IN(b_in), .PORT_B_OUT(b_out), .PORT_B_OE(b_oe));
  gpl_pin_model #(.W(8)) u_pins_a (.pin_out(a_out), .pin_oe(a_oe), .ext_val(a_ext),
    .pin_level(a_in));
  gpl_pin_model #(.W(4)) u_pins_b (.pin_out(b_out), .pin_oe(b_oe), .ext_val(b_ext),
    .pin_level(b_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // master never assumes a latency: it waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // outputs are looked at just after an edge, once its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(5);
    chk(32'({a_oe, b_oe}), 32'h0000_0000);
    @(posedge clk);
    rst_b <= 1'b1;
    rdchk(GPL_OFS_A_DIR, 32'h0000_0000);
    rdchk(GPL_OFS_B_DIR, 32'h0000_0000);
    wr(GPL_OFS_A_DATA, 32'h0000_00a5);
    chk(32'(err), 32'h0000_0000);
    settle(2);
    chk(32'(a_oe), 32'h0000_0000);
    rdchk(GPL_OFS_A_DATA, 32'h0000_003c);
    wr(GPL_OFS_CTRL, 32'h0000_0002);
    rdchk(GPL_OFS_A_DATA, 32'h0000_00a5);
    wr(GPL_OFS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      wr(GPL_OFS_A_DIR, 32'(8'h01 << i));
      settle(2);
      chk(32'(a_oe), 32'(8'h01 << i));
    end
    wr(GPL_OFS_A_DIR, 32'h0000_000f);
    settle(2);
    chk(32'(a_out), 32'h0000_00a5);
    rdchk(GPL_OFS_A_DATA, 32'h0000_0035);
    wr(GPL_OFS_A_DATA, 32'h0000_005a);
    settle(1);
    chk(32'(a_out), 32'h0000_005a);
    wr(GPL_OFS_B_DATA, 32'hffff_fff6);
    rdchk(GPL_OFS_B_DATA, 32'h0000_0009);
    wr(GPL_OFS_B_DIR, 32'hffff_ffff);
    rdchk(GPL_OFS_B_DIR, 32'h0000_000f);
    rdchk(GPL_OFS_B_DATA, 32'h0000_0006);
    settle(2);
    chk(32'({b_oe, b_out}), 32'h0000_00f6);
    // unmapped word: refused, nothing read back
    wr(8'h20, 32'h0000_00ff);
    chk(32'(err), 32'h0000_0001);
    rdchk(8'h20, 32'h0000_0000);
    // standby with float clear keeps every pin as it was
    @(posedge clk);
    stby <= 1'b1;
    settle(3);
    chk(32'({a_oe, a_out, b_oe, b_out}), 32'h000f_5af6);
    rdchk(GPL_OFS_STAT, 32'h0000_0001);
    @(posedge clk);
    stby <= 1'b0;
    wr(GPL_OFS_CTRL, 32'h0000_0001);
    @(posedge clk);
    stby <= 1'b1;
    settle(3);
    chk(32'({a_oe, b_oe}), 32'h0000_0000);
    rdchk(GPL_OFS_STAT, 32'h0000_0003);
    rdchk(GPL_OFS_A_DATA, 32'h0000_000a);
    @(posedge clk);
    stby <= 1'b0;
    settle(3);
    chk(32'({a_oe, b_oe}), 32'h0000_00ff);
    tally_and_finish();
  end
endmodule
